// [hdl/scc_system_control.sv]
// system control logic: control bits, status flags, disable-core mode
// Operation
// - write-protect error enable gates bus error
// - write-protect violation flag always sets
// - split clear: strobes held, grant unaffected
// - split set: strobes dropped, grant withheld
// - extra wait bit adds one external wait
// - extra wait clear: programmed waits exactly
// - decode-conflict enable gates bus error
// - decode-conflict flag sets except on configuration register access
// - bus-clear mask routes interrupt pending
// - pending interrupt flag always sets
// - asynchronous access uses three waits
// - synchronous reads one wait with extra
// - bus request becomes output when disabled
// - grant input, wait quiet, then acknowledge
// - bus clear input to independent dma
// - priority requests driven on interrupt outs
// - base register zero initial value
// - vector generation for level four
// - low power follows enable bit
// - status flags clear on write one
// - bus clear holds until flag cleared
`timescale 1ns/10ps
`default_nettype none
`include "scc_cfg.svh"

module scc_system_control
    import scc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    // control word write, status read
    input wire logic ctrl_we,
    input wire scc_ctrl_t ctrl_wdata,
    output scc_ctrl_t ctrl_q,
    input wire logic status_clear_we,
    input wire scc_status_t status_clear_mask,
    output scc_status_t status_q,
    // events from decode logic and core
    input wire logic write_protect_hit,
    input wire logic decode_conflict_hit,
    input wire logic config_reg_access,
    input wire logic core_interrupt_pending,
    // locked cycle control
    input wire logic locked_cycle_indicator,
    input wire logic locked_read_done,
    input wire logic locked_write_done,
    input wire logic strobe_request,
    output logic strobe_enable,
    output logic locked_grant_hold,
    output logic locked_write_waits,
    // wait-state computation
    input wire logic ext_master_cycle,
    input wire logic internal_target,
    input wire logic cs_dtack_used,
    input wire logic [3:0] programmed_waits,
    input wire logic cycle_is_read,
    output logic [3:0] wait_states,
    // bus error and bus clear
    output logic bus_error,
    output logic bus_clear_request_o,
    output logic bus_clear_request_oe,
    input wire logic bus_clear_request_i,
    output logic internal_bus_clear,
    input wire logic serial_dma_channels_request,
    input wire logic independent_dma_request,
    // disable-core mode pins
    input wire logic core_disable_strap,
    output logic core_disabled,
    output logic bus_request_o,
    output logic bus_request_oe,
    input wire logic bus_grant_i,
    output logic bus_grant_oe,
    input wire logic addr_strobe_i,
    input wire logic bus_error_i,
    input wire logic halt_i,
    input wire logic grant_ack_i,
    output logic grant_ack_o,
    output logic grant_ack_oe,
    input wire logic [2:0] priority_request,
    output logic [2:0] interrupt_out,
    output logic [2:0] interrupt_out_oe,
    input wire logic autovector_request,
    input wire logic chip_select_zero,
    output logic [15:0] base_register_zero,
    input wire logic [2:0] iack_level,
    input wire logic [7:0] level_vector_enable,
    output logic vector_supply,
    output logic low_power
);

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [5:0] pin_meta_q;
    logic [5:0] pin_sync_q;
    logic grant_low;
    logic as_low;
    logic berr_low;
    logic halt_low;
    logic bgack_low;
    logic bus_clear_request_in_low;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pin_meta_q <= 6'h3f;
            pin_sync_q <= 6'h3f;
        end
        else
        begin
            pin_meta_q <= {bus_grant_i, addr_strobe_i, bus_error_i, halt_i,
                grant_ack_i, bus_clear_request_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign grant_low = ~pin_sync_q[5];
    assign as_low = ~pin_sync_q[4];
    assign berr_low = ~pin_sync_q[3];
    assign halt_low = ~pin_sync_q[2];
    assign bgack_low = ~pin_sync_q[1];
    assign bus_clear_request_in_low = ~pin_sync_q[0];

    // ************************************************
    // strap capture
    // ************************************************
    logic strap_meta_q;
    logic strap_sync_q;
    always_ff @(posedge ref_clk)
    begin
        strap_meta_q <= core_disable_strap;
        strap_sync_q <= strap_meta_q;
    end

    // sampled while reset held, kept afterwards
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            core_disabled <= strap_sync_q;
    end

    // ************************************************
    // control bits
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            ctrl_q <= '0;
        else if (ctrl_we)
            ctrl_q <= ctrl_wdata;
    end

    // ************************************************
    // status flags
    // ************************************************
    logic wp_event;
    logic dc_event;
    // conflicts on configuration registers are not reported
    assign wp_event = write_protect_hit;
    assign dc_event = decode_conflict_hit & ~config_reg_access;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            status_q <= '0;
        else
        begin
            // set wins over clear
            status_q.pending_interrupt_flag <= core_interrupt_pending
                | (status_q.pending_interrupt_flag
                & ~(status_clear_we & status_clear_mask.pending_interrupt_flag));
            status_q.write_protect_violation_flag <= wp_event
                | (status_q.write_protect_violation_flag
                & ~(status_clear_we & status_clear_mask.write_protect_violation_flag));
            status_q.decode_conflict_flag <= dc_event
                | (status_q.decode_conflict_flag
                & ~(status_clear_we & status_clear_mask.decode_conflict_flag));
        end
    end

    // ************************************************
    // bus error
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            bus_error <= 1'b0;
        else
            bus_error <= (wp_event & ctrl_q.write_protect_error_enable)
                | (dc_event & ctrl_q.decode_conflict_error_enable);
    end

    // ************************************************
    // locked read-modify-write handling
    // ************************************************
    logic locked_gap_q;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            locked_gap_q <= 1'b0;
        else if (!ctrl_q.locked_cycle_split || !locked_cycle_indicator)
            locked_gap_q <= 1'b0;
        else if (locked_read_done)
            locked_gap_q <= 1'b1;
        else if (strobe_request)
            locked_gap_q <= 1'b0;
    end

    always_comb
    begin
        // split: one idle slot between read and write portions
        strobe_enable = strobe_request & ~locked_gap_q;
        locked_grant_hold = ctrl_q.locked_cycle_split & locked_cycle_indicator
            & ~locked_write_done;
        locked_write_waits = ctrl_q.locked_cycle_split;
    end

    // ************************************************
    // wait states
    // ************************************************
    function automatic logic [3:0] add_extra(input logic [3:0] base, input logic extra);
        add_extra = base + {3'h0, extra};
    endfunction : add_extra
    logic [3:0] wait_d;
    always_comb
    begin
        wait_d = programmed_waits;
        if (locked_cycle_indicator && !cycle_is_read && !ctrl_q.locked_cycle_split
            && cs_dtack_used)
            wait_d = 4'h0;
        else if (ext_master_cycle && internal_target)
        begin
            if (!ctrl_q.sync_access_select)
                wait_d = `SCC_ASYNC_WAITS;
            else
                wait_d = add_extra(4'h0, ctrl_q.ext_master_extra_wait);
        end
        else if (ext_master_cycle && cs_dtack_used)
            wait_d = add_extra(programmed_waits, ctrl_q.ext_master_extra_wait);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            wait_states <= 4'h0;
        else
            wait_states <= wait_d;
    end

    // ************************************************
    // bus clear
    // ************************************************
    logic ipa_clear_hold;
    // held by the sticky flag until software clears it
    assign ipa_clear_hold = ctrl_q.bus_clear_interrupt_mask
        & status_q.pending_interrupt_flag;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            bus_clear_request_o <= 1'b0;
            internal_bus_clear <= 1'b0;
        end
        else
        begin
            bus_clear_request_o <= (serial_dma_channels_request & ~independent_dma_request) | ipa_clear_hold;
            internal_bus_clear <= ipa_clear_hold
                | (core_disabled & bus_clear_request_in_low);
        end
    end

    // in disable mode the pin is an input to the independent engine, except while a serial dma request without an independent one drives it
    assign bus_clear_request_oe = ~core_disabled | (serial_dma_channels_request & ~independent_dma_request);

    // ************************************************
    // external arbitration in disable-core mode
    // ************************************************
    scc_grant_state_t grant_state_q;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            grant_state_q <= GRANT_IDLE;
        else
        begin
            case (grant_state_q)
                GRANT_IDLE:
                    if (core_disabled && (serial_dma_channels_request || independent_dma_request) && grant_low)
                        grant_state_q <= GRANT_WAIT_QUIET;
                GRANT_WAIT_QUIET:
                    if (!as_low && !berr_low && !halt_low && !bgack_low)
                        grant_state_q <= GRANT_OWN;
                GRANT_OWN:
                    if (!serial_dma_channels_request && !independent_dma_request)
                        grant_state_q <= GRANT_IDLE;
                default:
                    grant_state_q <= GRANT_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            bus_request_o <= 1'b1;
        else
            bus_request_o <= ~(core_disabled & (serial_dma_channels_request | independent_dma_request)
                & (grant_state_q != GRANT_OWN));
    end

    assign bus_request_oe = core_disabled;
    assign bus_grant_oe = ~core_disabled;
    assign grant_ack_o = ~(grant_state_q == GRANT_OWN);
    assign grant_ack_oe = grant_state_q == GRANT_OWN;

    // ************************************************
    // interrupt outputs and vectors
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            interrupt_out <= 3'h7;
        else if (core_disabled)
            interrupt_out <= priority_request;
        else
            interrupt_out <= {chip_select_zero, locked_cycle_indicator, autovector_request};
    end

    assign interrupt_out_oe = 3'h7;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            base_register_zero <= `SCC_BR0_NORMAL_INIT;
        else if (core_disabled && base_register_zero == `SCC_BR0_NORMAL_INIT)
            base_register_zero <= `SCC_BR0_DISABLED_INIT;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            vector_supply <= 1'b0;
        else
            vector_supply <= core_disabled & ctrl_q.vector_gen_enable
                & ((iack_level == `SCC_VEC_LEVEL4) | level_vector_enable[iack_level]);
    end

    // ************************************************
    // low power
    // ************************************************
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            low_power <= 1'b0;
        else
            low_power <= core_disabled & ctrl_q.low_power_enable;
    end

endmodule : scc_system_control
`default_nettype wire

// [hdl/scc_cfg.svh]
// system control constants: reset values, wait counts, vector level, function code
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_ASYNC_WAITS 4'h3
`define SCC_BR0_DISABLED_INIT 16'hc000
`define SCC_BR0_NORMAL_INIT 16'h0000
`define SCC_VEC_LEVEL4 3'h4
`define SCC_FC_CPU_SPACE 3'h7
`define SCC_CTRL_RESET 1'b0
`endif

// [hdl/scc_pkg.sv]
// system control types
package scc_pkg;
    typedef struct packed {
        logic write_protect_error_enable;
        logic locked_cycle_split;
        logic ext_master_extra_wait;
        logic decode_conflict_error_enable;
        logic bus_clear_interrupt_mask;
        logic sync_access_select;
        logic vector_gen_enable;
        logic low_power_enable;
    } scc_ctrl_t;
    typedef struct packed {
        logic pending_interrupt_flag;
        logic write_protect_violation_flag;
        logic decode_conflict_flag;
    } scc_status_t;
    typedef enum logic [1:0] {
        GRANT_IDLE,
        GRANT_WAIT_QUIET,
        GRANT_OWN
    } scc_grant_state_t;
endpackage : scc_pkg

// [tb/scc_system_control_asserts.sv]
// assertion checker for the system control block
`timescale 1ns/10ps
`default_nettype none
module scc_sc_asserts
    import scc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire scc_ctrl_t ctrl_q,
    input wire scc_status_t status_q,
    input wire logic write_protect_hit,
    input wire logic decode_conflict_hit,
    input wire logic config_reg_access,
    input wire logic bus_error,
    input wire logic bus_clear_request_o,
    input wire logic ext_master_cycle,
    input wire logic internal_target,
    input wire logic cycle_is_read,
    input wire logic [3:0] wait_states,
    input wire logic core_disabled,
    input wire logic [2:0] priority_request,
    input wire logic [2:0] interrupt_out,
    input wire logic [2:0] iack_level,
    input wire logic vector_supply,
    input wire logic grant_ack_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic wp_err = write_protect_hit && ctrl_q.write_protect_error_enable;
    wire logic dc_hit = decode_conflict_hit && !config_reg_access;
    wire logic dc_err = dc_hit && ctrl_q.decode_conflict_error_enable;
    wire logic ext_int = ext_master_cycle && internal_target;
    // ********
    // properties
    // ********
    a_wp_berr: assert property (
        wp_err |=> bus_error) else $error("wp berr");
    a_berr_cause: assert property (
        bus_error |-> $past(wp_err || dc_err)) else $error("stray berr");
    a_wp_flag: assert property (
        write_protect_hit |=> status_q.write_protect_violation_flag) else $error("wp flag");
    a_dc_flag: assert property (
        dc_hit |=> status_q.decode_conflict_flag) else $error("dc flag");
    a_bus_clear_request_hold: assert property (
        (ctrl_q.bus_clear_interrupt_mask && status_q.pending_interrupt_flag) [*2]
        |-> bus_clear_request_o) else $error("bus_clear_request");
    a_async_wait: assert property (
        ext_int && !ctrl_q.sync_access_select |=> wait_states == 4'h3) else $error("async");
    a_sync_wait: assert property (
        ext_int && ctrl_q.sync_access_select && cycle_is_read
        |=> wait_states == {3'h0, $past(ctrl_q.ext_master_extra_wait)}) else $error("sync");
    a_vector_gen: assert property (
        core_disabled && iack_level == 3'h4
        |=> vector_supply == $past(ctrl_q.vector_gen_enable)) else $error("vector");
    a_iout_map: assert property (
        core_disabled [*2] |-> interrupt_out == $past(priority_request)) else $error("iout");
    c_berr: cover property (bus_error);
    c_bus_clear_request: cover property (bus_clear_request_o);
    c_gack: cover property (grant_ack_oe);
endmodule : scc_sc_asserts
bind scc_system_control scc_sc_asserts u_chk (.*);
`default_nettype wire

// [tb/scc_ext_master.sv]
// bus master model that owns the bus and hands it over on request
`timescale 1ns/10ps
`default_nettype none
module scc_ext_master (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic req_n,
    output logic bg_n,
    output logic as_n
);
    int busy = 0;
    // ********
    // grant follows request; a slow master finishes its own cycle first
    // ********
    // plain data cycles only, never the cpu-space function code
    initial
    begin
        {bg_n, as_n} = 2'h3;
        forever
        begin
            @(posedge ref_clk);
            #2;
            bg_n = req_n;
            busy = req_n ? (slow ? 5 : 0) : (busy > 0 ? busy - 1 : 0);
            as_n = busy == 0;
        end
    end
endmodule : scc_ext_master
`default_nettype wire

// [tb/scc_system_control_tb.sv]
// self-checking bench for the system control block
`timescale 1ns/10ps
`default_nettype none
module scc_system_control_tb;
    import scc_pkg::*;
    logic ref_clk = 1'h0;
    logic reset, ctrl_we, status_clear_we, write_protect_hit, decode_conflict_hit;
    logic config_reg_access, core_interrupt_pending, locked_cycle_indicator, locked_read_done;
    logic locked_write_done, strobe_request, ext_master_cycle, internal_target, cs_dtack_used;
    logic cycle_is_read, bus_clear_request_i, serial_dma_channels_request, independent_dma_request, core_disable_strap;
    logic autovector_request, chip_select_zero, halt_i, bus_error_i, slow, bus_grant_i;
    logic strobe_enable, locked_grant_hold, locked_write_waits, bus_error, bus_clear_request_o;
    logic bus_clear_request_oe, internal_bus_clear, core_disabled, bus_request_o, addr_strobe_i;
    logic bus_request_oe, bus_grant_oe, grant_ack_o, grant_ack_oe, vector_supply, low_power;
    logic [2:0] priority_request, iack_level, interrupt_out, interrupt_out_oe;
    logic [3:0] programmed_waits, wait_states;
    logic [7:0] level_vector_enable;
    logic [15:0] base_register_zero, lfsr_q, r;
    scc_ctrl_t ctrl_wdata, ctrl_q, cw;
    scc_status_t status_clear_mask, status_q;
    int mismatches = 0, n_tests = 0, n;
    wire logic grant_ack_i = grant_ack_oe ? grant_ack_o : 1'h1;
    wire logic req_w = bus_request_oe ? bus_request_o : 1'h1;

    scc_system_control u_dut (.*);
    scc_ext_master u_master (.ref_clk(ref_clk), .slow(slow), .req_n(req_w),
        .bg_n(bus_grant_i), .as_n(addr_strobe_i));

    always #12.5 ref_clk = ~ref_clk;

    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    function automatic logic [3:0] exp_waits(logic [15:0] v);
        if (v[3])
            return v[0] ? {3'h0, v[1]} : 4'h3;
        return {1'h0, v[7:5]} + {3'h0, v[1]};
    endfunction : exp_waits

    function automatic logic exp_vec(int i);
        return i[3] && (i[2:0] == 3'h4 || (i[4] && i[2:0] inside {3'h1, 3'h6, 3'h7}));
    endfunction : exp_vec

    task automatic tick(int k = 1);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask : tick

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic set_ctrl(scc_ctrl_t c);
        ctrl_wdata = c;
        ctrl_we = 1'h1;
        tick();
        ctrl_we = 1'h0;
        tick();
    endtask : set_ctrl

    task automatic clear_flags(logic [2:0] m);
        status_clear_mask = m;
        status_clear_we = 1'h1;
        tick();
        status_clear_we = 1'h0;
        tick();
    endtask : clear_flags

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    initial
    begin
        #(25 * 5000);
        mismatches++;
        report_and_stop();
    end

    // ********
    // scenarios
    // ********
    initial
    begin
        {ctrl_we, status_clear_we, write_protect_hit, decode_conflict_hit} = '0;
        {config_reg_access, core_interrupt_pending, locked_cycle_indicator, locked_read_done} = '0;
        {locked_write_done, strobe_request, ext_master_cycle, internal_target, cs_dtack_used} = '0;
        {cycle_is_read, serial_dma_channels_request, independent_dma_request, autovector_request, chip_select_zero} = '0;
        {slow, priority_request, iack_level, programmed_waits, level_vector_enable} = '0;
        {ctrl_wdata, status_clear_mask, cw} = '0;
        {reset, core_disable_strap, halt_i, bus_error_i, bus_clear_request_i} = '1;
        lfsr_q = 16'hae86;
        tick(5);
        reset = 1'h0;
        tick();
        chk("ctrl", 16'h0, ctrl_q);
        chk("stat", 16'h0, status_q);
        chk("br0", 16'hc000, base_register_zero);
        chk("br oe", 16'h1, bus_request_oe);
        chk("bg oe", 16'h0, bus_grant_oe);
        chk("iout oe", 16'h7, interrupt_out_oe);
        // error enables against each event, conflict during config access refused
        for (int i = 0; i < 6; i++)
        begin
            cw = '0;
            cw.write_protect_error_enable = i[0];
            cw.decode_conflict_error_enable = i[0];
            set_ctrl(cw);
            {write_protect_hit, decode_conflict_hit, config_reg_access} = {i < 2, i >= 2, i >= 4};
            tick();
            {write_protect_hit, decode_conflict_hit, config_reg_access} = 3'h0;
            chk("berr", i[0] && i < 4, bus_error);
            chk("wpv", i < 2, status_q.write_protect_violation_flag);
            chk("adc", i == 2 || i == 3, status_q.decode_conflict_flag);
            tick();
            chk("berr end", 16'h0, bus_error);
            clear_flags(3'h7);
            chk("clr", 16'h0, status_q);
        end
        // pending interrupt with mask off, then on until flag cleared
        for (int m = 0; m < 2; m++)
        begin
            cw = '0;
            cw.bus_clear_interrupt_mask = m[0];
            set_ctrl(cw);
            core_interrupt_pending = 1'h1;
            tick();
            core_interrupt_pending = 1'h0;
            tick(3);
            chk("ipa", 16'h1, status_q.pending_interrupt_flag);
            chk("bus_clear_request", m[0], bus_clear_request_o);
            chk("internal_bus_clear", m[0], internal_bus_clear);
            clear_flags(3'h3);
            chk("bus_clear_request keep", m[0], bus_clear_request_o);
            clear_flags(3'h4);
            tick();
            chk("bus_clear_request off", 16'h0, bus_clear_request_o);
            chk("internal_bus_clear off", 16'h0, internal_bus_clear);
            chk("ipa clr", 16'h0, status_q.pending_interrupt_flag);
        end
        // every acknowledge level with vector generation off and on
        for (int i = 0; i < 32; i++)
        begin
            cw = '0;
            cw.vector_gen_enable = i[3];
            set_ctrl(cw);
            iack_level = i[2:0];
            level_vector_enable = i[4] ? 8'hc2 : 8'h00;
            tick();
            chk("vec", exp_vec(i), vector_supply);
        end
        {iack_level, level_vector_enable} = '0;
        // locked cycle with split clear and set
        for (int s = 0; s < 2; s++)
        begin
            cw = '0;
            cw.locked_cycle_split = s[0];
            set_ctrl(cw);
            {locked_cycle_indicator, strobe_request, locked_read_done} = 3'h7;
            tick();
            {strobe_request, locked_read_done} = 2'h0;
            tick();
            chk("hold", s[0], locked_grant_hold);
            chk("lwait", s[0], locked_write_waits);
            {cs_dtack_used, programmed_waits} = {1'h1, 4'h3};
            strobe_request = 1'h1;
            #1;
            chk("gap", !s[0], strobe_enable);
            tick();
            chk("restrobe", 16'h1, strobe_enable);
            chk("lock waits", s[0] ? 16'h3 : 16'h0, wait_states);
            locked_write_done = 1'h1;
            tick();
            {locked_cycle_indicator, strobe_request, locked_write_done, cs_dtack_used} = 4'h0;
            tick();
            chk("free", 16'h0, locked_grant_hold);
        end
        // random external master cycles, first one a hand-picked corner
        for (int i = 0; i < 60; i++)
        begin
            lfsr_q = lfsr(lfsr_q);
            r = i == 0 ? 16'h00e2 : lfsr_q;
            cw = '0;
            {cw.low_power_enable, cw.ext_master_extra_wait, cw.sync_access_select} = r[2:0];
            set_ctrl(cw);
            {ext_master_cycle, internal_target, cs_dtack_used} = {1'h1, r[3], !r[3]};
            cycle_is_read = r[4] | r[0];
            programmed_waits = {1'h0, r[7:5]};
            priority_request = r[10:8];
            {bus_clear_request_i, independent_dma_request} = r[12:11];
            tick();
            chk("waits", exp_waits(r), wait_states);
            chk("iout", r[10:8], interrupt_out);
            chk("lp", r[2], low_power);
        end
        {ext_master_cycle, bus_clear_request_i, independent_dma_request} = 3'h0;
        tick(3);
        chk("internal_bus_clear pin", 16'h1, internal_bus_clear);
        chk("bus_clear_request oe", 16'h0, bus_clear_request_oe);
        bus_clear_request_i = 1'h1;
        // device asks for the bus, prompt and slow master
        for (int s = 0; s < 2; s++)
        begin
            slow = s[0];
            tick(2);
            serial_dma_channels_request = 1'h1;
            n = 0;
            while (n < 50 && !(grant_ack_oe === 1'h1 && grant_ack_o === 1'h0))
            begin
                tick();
                n++;
            end
            chk("br", 16'h0, bus_request_o);
            chk("bus_clear_request oe serial_dma_channels", 16'h1, bus_clear_request_oe);
            chk("bus_clear_request serial_dma_channels", 16'h1, bus_clear_request_o);
            chk("gack", 16'h1, n >= (s ? 5 : 1) && n < 50);
            chk("as quiet", 16'h1, addr_strobe_i);
            serial_dma_channels_request = 1'h0;
            tick(10);
        end
        core_disable_strap = 1'h0;
        reset = 1'h1;
        tick(5);
        reset = 1'h0;
        tick();
        chk("br0 norm", 16'h0, base_register_zero);
        chk("br oe", 16'h0, bus_request_oe);
        chk("bg oe", 16'h1, bus_grant_oe);
        report_and_stop();
    end
endmodule : scc_system_control_tb
`default_nettype wire
